/* rtl/ssc_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the status pin block
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
`define SSC_A_CTRL 8'h00
`define SSC_A_OVP 8'h04
`define SSC_A_OCP 8'h08
`define SSC_A_RISE 8'h0C
`define SSC_A_FALL 8'h10
`define SSC_A_LINE_LO 8'h14
`define SSC_A_LINE_HI 8'h18
`define SSC_A_STATUS 8'h1C
`define SSC_A_INT_STAT 8'h20
`define SSC_A_INT_MASK 8'h24
// Control fields
`define SSC_C_OUT_EN 0
`define SSC_C_REMOTE_USE 1
`define SSC_C_TRIG_EN 2
`define SSC_C_FOLD_V2C 3
`define SSC_C_FOLD_C2V 4
`define SSC_CTRL_W 5
// Event bits: nine protections, then the trigger
`define SSC_P_OV 0
`define SSC_P_OC 1
`define SSC_P_OP 2
`define SSC_P_OT 3
`define SSC_P_FAN 4
`define SSC_P_LINE 5
`define SSC_P_SENSE 6
`define SSC_P_V2C 7
`define SSC_P_C2V 8
`define SSC_E_TRIG 9
`define SSC_NPROT 9
`define SSC_NEV 10
// Reset values
`define SSC_CTRL_RST 5'h00
`define SSC_OVP_RST 16'hFFFF
`define SSC_OCP_RST 16'hFFFF
`define SSC_RISE_RST 16'h0100
`define SSC_FALL_RST 16'h0080
`define SSC_LINE_LO_RST 16'h0000
`define SSC_LINE_HI_RST 16'hFFFF
`define SSC_MASK_RST 10'h000
// Synchroniser and filter idle levels, bit order as the pin vector
`define SSC_PIN_RST 8'h5A
// Filter settle time in clock cycles
`define SSC_DEB_CYC 16
// Rated limits, plain defaults
`define SSC_RATED_V 16'hF000
`define SSC_RATED_I 16'hF000
`define SSC_RATED_P 16'hF000
`endif

/* rtl/ssc_pkg.sv */
// Types shared by the status pin block
package ssc_pkg;
  typedef enum logic [1:0] {
    SSC_OFF = 2'b00,
    SSC_ON = 2'b01,
    SSC_TOFF = 2'b10
  } ssc_state_t;
  typedef logic [15:0] ssc_word_t;
endpackage

/* rtl/ssc_status_pins.sv */
// Rear connector control inputs, status outputs and protection flags with APB registers
`timescale 1ns/10ps
`include "ssc_cfg.svh"

// Notes on behaviour
// - With sequence triggering enabled, a rising edge on the trigger pin is one trigger event.
// - An asserted inhibit input turns an active output off.
// - Output-on status goes high when the output is on and voltage exceeds the rise threshold.
// - Output-on status goes low when voltage drops below the fall threshold.
// - The mode flag is high in constant voltage and low in constant current regulation.
// - An asserted temporary_off_in holds the output in a temporary off state.
// - The remote on/off input turns the output on and off when it is in use.
// - The summary fault pin goes low when any protection is active.
// - The over-temperature pin goes low when over-temperature protection is active.
// - Nine protection causes are detected and reported as status bits.
// - Over-current trips above the rated limit or the programmed setting.
// - Over-power trips above the rated limit.
// - Over-voltage trips above the rated limit or the programmed setting.
// - Input line trips when below or above its permitted window.
// - Fan failure trips when fan feedback reports the fan not running.
// - Over-voltage disables the output, using a 16-bit threshold.
module ssc_status_pins #(
  parameter int DEB_CYC = `SSC_DEB_CYC,
  parameter logic [15:0] RATED_V = `SSC_RATED_V,
  parameter logic [15:0] RATED_I = `SSC_RATED_I,
  parameter logic [15:0] RATED_P = `SSC_RATED_P
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SEQUENCE_TRIGGER_IN,
  input wire logic INHIBIT_IN_N,
  input wire logic TEMPORARY_OFF_IN,
  input wire logic REMOTE_ONOFF_IN_N,
  input wire logic CV_MODE_IN,
  input wire logic OTP_IN,
  input wire logic FAN_OK_IN,
  input wire logic SENSE_FAULT_IN,
  input wire logic [15:0] VOUT_MEAS,
  input wire logic [15:0] IOUT_MEAS,
  input wire logic [15:0] POUT_MEAS,
  input wire logic [15:0] LINE_MEAS,
  output logic OUTPUT_ENABLE,
  output logic OUTPUT_ACTIVE_STATUS,
  output logic REGULATION_MODE_FLAG,
  output logic FAULT_N,
  output logic OTP_N,
  output logic TRIG_PULSE,
  output logic IRQ
);

  // Elaboration check: the filter counter is 16 bits wide
  if (DEB_CYC < 1 || DEB_CYC > 65535) begin : g_bad_deb
    $error("DEB_CYC must lie in 1..65535");
  end

  // Pin vector, one filter each
  logic [7:0] pin_raw;
  logic [7:0] flt;
  assign pin_raw = {SENSE_FAULT_IN, FAN_OK_IN, OTP_IN, CV_MODE_IN,
                    REMOTE_ONOFF_IN_N, TEMPORARY_OFF_IN, INHIBIT_IN_N, SEQUENCE_TRIGGER_IN};

  // Two-stage synchroniser then a stability counter; only a level held for
  // DEB_CYC cycles passes, so contact bounce never reaches the edge detector
  for (genvar i = 0; i < 8; i++) begin : g_pin
    localparam logic [7:0] PIN_RST = `SSC_PIN_RST;
    localparam logic RV = PIN_RST[i];
    logic s1_q, s2_q, f_q, f_d;
    logic [15:0] cnt_q, cnt_d;
    always_comb begin
      f_d = f_q;
      cnt_d = 16'h0000;
      if (s2_q != f_q) begin
        if (cnt_q == 16'(DEB_CYC - 1)) begin
          f_d = s2_q;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
    end
    always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
        s1_q <= RV;
        s2_q <= RV;
        f_q <= RV;
        cnt_q <= 16'h0000;
      end else begin
        s1_q <= pin_raw[i];
        s2_q <= s1_q;
        f_q <= f_d;
        cnt_q <= cnt_d;
      end
    end
    assign flt[i] = f_q;
  end

  // Filtered levels, active high
  logic trig_f, inh_f, ilk_f, remote_on_f, cv_f, otp_f, fan_ok_f, sense_f;
  assign trig_f = flt[0];
  assign inh_f = ~flt[1];
  assign ilk_f = flt[2];
  assign remote_on_f = ~flt[3];
  assign cv_f = flt[4];
  assign otp_f = flt[5];
  assign fan_ok_f = flt[6];
  assign sense_f = flt[7];

  // Register state
  logic [`SSC_CTRL_W-1:0] ctrl_q, ctrl_d;
  ssc_pkg::ssc_word_t ovp_q, ovp_d, ocp_q, ocp_d, rise_q, rise_d, fall_q, fall_d;
  ssc_pkg::ssc_word_t line_lo_q, line_lo_d, line_hi_q, line_hi_d;
  logic [`SSC_NEV-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] status_word;
  logic wr_en, rd_setup, addr_ok;

  // Core state
  ssc_pkg::ssc_state_t state_q, state_d;
  logic out_en_q, out_en_d, dcon_q, dcon_d, mode_q, fault_n_q, fault_n_d;
  logic otp_n_q, otp_n_d, trig_prev_q, trig_pulse_q, trig_pulse_d, cv_prev_q;
  logic irq_q, irq_d;
  logic [`SSC_NPROT-1:0] prot;
  logic trig_rise, fault_any, en_req;

  // Live protection conditions
  always_comb begin
    prot[`SSC_P_OV] = (VOUT_MEAS > RATED_V) || (VOUT_MEAS > ovp_q);
    prot[`SSC_P_OC] = (IOUT_MEAS > RATED_I) || (IOUT_MEAS > ocp_q);
    prot[`SSC_P_OP] = POUT_MEAS > RATED_P;
    prot[`SSC_P_OT] = otp_f;
    prot[`SSC_P_FAN] = ~fan_ok_f;
    prot[`SSC_P_LINE] = (LINE_MEAS < line_lo_q) || (LINE_MEAS > line_hi_q);
    prot[`SSC_P_SENSE] = sense_f;
    // Foldback counts only a mode change while the output is driving
    prot[`SSC_P_V2C] = ctrl_q[`SSC_C_FOLD_V2C] & out_en_q & cv_prev_q & ~cv_f;
    prot[`SSC_P_C2V] = ctrl_q[`SSC_C_FOLD_C2V] & out_en_q & ~cv_prev_q & cv_f;
  end

  // Latched faults keep the output off until software clears them
  assign fault_any = (|prot) | (|stat_q[`SSC_NPROT-1:0]);
  assign trig_rise = ctrl_q[`SSC_C_TRIG_EN] & trig_f & ~trig_prev_q;
  // Remote pin only counts when selected, else it is treated as on
  assign en_req = ctrl_q[`SSC_C_OUT_EN] & (~ctrl_q[`SSC_C_REMOTE_USE] | remote_on_f);

  // Output state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ssc_pkg::SSC_OFF: begin
        if (en_req && !inh_f && !ilk_f && !fault_any) begin
          state_d = ssc_pkg::SSC_ON;
        end
      end
      ssc_pkg::SSC_ON: begin
        if (fault_any || !en_req || inh_f) begin
          state_d = ssc_pkg::SSC_OFF;
        end else if (ilk_f) begin
          state_d = ssc_pkg::SSC_TOFF;
        end
      end
      ssc_pkg::SSC_TOFF: begin
        if (fault_any || !en_req || inh_f) begin
          state_d = ssc_pkg::SSC_OFF;
        end else if (!ilk_f) begin
          state_d = ssc_pkg::SSC_ON;
        end
      end
      default: begin
        state_d = ssc_pkg::SSC_OFF;
      end
    endcase
  end

  // Status pin next values
  always_comb begin
    out_en_d = (state_d == ssc_pkg::SSC_ON);
    dcon_d = dcon_q;
    if (out_en_q && VOUT_MEAS > rise_q) begin
      dcon_d = 1'b1;
    end else if (VOUT_MEAS < fall_q) begin
      dcon_d = 1'b0;
    end
    fault_n_d = ~fault_any;
    otp_n_d = ~(prot[`SSC_P_OT] | stat_q[`SSC_P_OT]);
    trig_pulse_d = trig_rise;
  end

  // APB decode; the slave never waits
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE;
  assign PREADY = 1'b1;
  always_comb begin
    unique case (PADDR)
      `SSC_A_CTRL, `SSC_A_OVP, `SSC_A_OCP, `SSC_A_RISE, `SSC_A_FALL, `SSC_A_LINE_LO,
      `SSC_A_LINE_HI, `SSC_A_STATUS, `SSC_A_INT_STAT, `SSC_A_INT_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;

  assign status_word = {7'h00, prot, 8'h00, remote_on_f, ilk_f, inh_f, mode_q, dcon_q,
                        out_en_q, state_q};

  // Register writes and sticky event bits
  always_comb begin
    ctrl_d = ctrl_q;
    ovp_d = ovp_q;
    ocp_d = ocp_q;
    rise_d = rise_q;
    fall_d = fall_q;
    line_lo_d = line_lo_q;
    line_hi_d = line_hi_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_en) begin
      unique case (PADDR)
        `SSC_A_CTRL: ctrl_d = PWDATA[`SSC_CTRL_W-1:0];
        `SSC_A_OVP: ovp_d = PWDATA[15:0];
        `SSC_A_OCP: ocp_d = PWDATA[15:0];
        `SSC_A_RISE: rise_d = PWDATA[15:0];
        `SSC_A_FALL: fall_d = PWDATA[15:0];
        `SSC_A_LINE_LO: line_lo_d = PWDATA[15:0];
        `SSC_A_LINE_HI: line_hi_d = PWDATA[15:0];
        `SSC_A_INT_STAT: stat_d = stat_q & ~PWDATA[`SSC_NEV-1:0];
        `SSC_A_INT_MASK: mask_d = PWDATA[`SSC_NEV-1:0];
        default: ;
      endcase
    end
    // Set after clear so an event in the clearing cycle survives
    stat_d = stat_d | {trig_rise, prot};
    irq_d = |(stat_d & mask_d);
    prdata_d = prdata_q;
    if (rd_setup) begin
      unique case (PADDR)
        `SSC_A_CTRL: prdata_d = {27'h0000000, ctrl_q};
        `SSC_A_OVP: prdata_d = {16'h0000, ovp_q};
        `SSC_A_OCP: prdata_d = {16'h0000, ocp_q};
        `SSC_A_RISE: prdata_d = {16'h0000, rise_q};
        `SSC_A_FALL: prdata_d = {16'h0000, fall_q};
        `SSC_A_LINE_LO: prdata_d = {16'h0000, line_lo_q};
        `SSC_A_LINE_HI: prdata_d = {16'h0000, line_hi_q};
        `SSC_A_STATUS: prdata_d = status_word;
        `SSC_A_INT_STAT: prdata_d = {22'h000000, stat_q};
        `SSC_A_INT_MASK: prdata_d = {22'h000000, mask_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  // All state registers except the pin filters
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= `SSC_CTRL_RST;
      ovp_q <= `SSC_OVP_RST;
      ocp_q <= `SSC_OCP_RST;
      rise_q <= `SSC_RISE_RST;
      fall_q <= `SSC_FALL_RST;
      line_lo_q <= `SSC_LINE_LO_RST;
      line_hi_q <= `SSC_LINE_HI_RST;
      mask_q <= `SSC_MASK_RST;
      stat_q <= 10'h000;
      prdata_q <= 32'h00000000;
      state_q <= ssc_pkg::SSC_OFF;
      out_en_q <= 1'b0;
      dcon_q <= 1'b0;
      mode_q <= 1'b1;
      fault_n_q <= 1'b1;
      otp_n_q <= 1'b1;
      trig_prev_q <= 1'b0;
      trig_pulse_q <= 1'b0;
      cv_prev_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ovp_q <= ovp_d;
      ocp_q <= ocp_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      line_lo_q <= line_lo_d;
      line_hi_q <= line_hi_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      prdata_q <= prdata_d;
      state_q <= state_d;
      out_en_q <= out_en_d;
      dcon_q <= dcon_d;
      mode_q <= cv_f;
      fault_n_q <= fault_n_d;
      otp_n_q <= otp_n_d;
      trig_prev_q <= trig_f;
      trig_pulse_q <= trig_pulse_d;
      cv_prev_q <= cv_f;
      irq_q <= irq_d;
    end
  end

  assign PRDATA = prdata_q;
  assign OUTPUT_ENABLE = out_en_q;
  assign OUTPUT_ACTIVE_STATUS = dcon_q;
  assign REGULATION_MODE_FLAG = mode_q;
  assign FAULT_N = fault_n_q;
  assign OTP_N = otp_n_q;
  assign TRIG_PULSE = trig_pulse_q;
  assign IRQ = irq_q;

  // Checks on the block's own outputs
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  a_trig_edge_pulse: assert property (
    ctrl_q[`SSC_C_TRIG_EN] && trig_f && !trig_prev_q |=> TRIG_PULSE ##1 !TRIG_PULSE)
    else $error("trigger edge did not give one pulse");
  a_inhibit_turns_off: assert property (
    inh_f |=> !OUTPUT_ENABLE)
    else $error("output stayed on under inhibit");
  a_active_rise: assert property (
    out_en_q && VOUT_MEAS > rise_q |=> OUTPUT_ACTIVE_STATUS)
    else $error("output-on status missed rise threshold");
  a_active_fall: assert property (
    !(out_en_q && VOUT_MEAS > rise_q) && VOUT_MEAS < fall_q |=> !OUTPUT_ACTIVE_STATUS)
    else $error("output-on status missed fall threshold");
  a_mode_follows: assert property (
    REGULATION_MODE_FLAG == $past(cv_f))
    else $error("mode flag does not follow regulation mode");
  a_temporary_off_in_off: assert property (
    ilk_f |=> !OUTPUT_ENABLE)
    else $error("output stayed on with temporary_off_in open");
  a_remote_turns_on: assert property (
    state_q == ssc_pkg::SSC_OFF && en_req && !inh_f && !ilk_f && !fault_any
    |=> OUTPUT_ENABLE)
    else $error("remote on request ignored");
  a_fault_low: assert property (
    |prot |=> !FAULT_N [*2])
    else $error("fault pin not low on protection");
  a_otp_low: assert property (
    otp_f |=> !OTP_N)
    else $error("over-temperature pin not low");
  a_ocp_latch: assert property (
    IOUT_MEAS > ocp_q |=> stat_q[`SSC_P_OC] && !OUTPUT_ENABLE)
    else $error("over-current not latched");
  a_ovp_off: assert property (
    VOUT_MEAS > ovp_q |=> !OUTPUT_ENABLE ##1 !OUTPUT_ENABLE)
    else $error("output not disabled on over-voltage");
  // Rated over-voltage, over-power, line, fan and sense causes latch, foldback turns the output off, and the interrupt tracks the masked status
  a_ovp_rated: assert property (
    VOUT_MEAS > RATED_V |=> stat_q[`SSC_P_OV] && !OUTPUT_ENABLE)
    else $error("rated over-voltage not latched");
  a_opp_latch: assert property (
    POUT_MEAS > RATED_P |=> stat_q[`SSC_P_OP] && !FAULT_N)
    else $error("over-power not latched");
  a_line_window: assert property (
    LINE_MEAS < line_lo_q || LINE_MEAS > line_hi_q |=> stat_q[`SSC_P_LINE])
    else $error("input line fault not latched");
  a_fan_fail: assert property (
    !fan_ok_f |=> stat_q[`SSC_P_FAN] && !FAULT_N)
    else $error("fan failure not latched");
  a_sense_latch: assert property (
    sense_f |=> stat_q[`SSC_P_SENSE])
    else $error("sense fault not latched");
  a_fold_off: assert property (
    prot[`SSC_P_V2C] || prot[`SSC_P_C2V] |=> !OUTPUT_ENABLE)
    else $error("foldback did not turn the output off");
  a_irq_level: assert property (
    IRQ == |(stat_q & mask_q))
    else $error("interrupt does not follow masked status");
endmodule

/* verif/ssc_ext_equip.sv */
// Model of the automation equipment that drives the rear control pins
`timescale 1ns/10ps
module ssc_ext_equip (
  input wire logic MCLK,
  input wire logic [7:0] LEVELS,
  output logic [7:0] PINS
);
  // Bits: trigger, inhibit_n, temp off, remote_n, cv, over-temp, fan ok, sense fault
  // Idle: inhibit and remote released, CV regulation, fan running
  // The equipment's output stage adds one register, so pins change just after an edge
  always_ff @(posedge MCLK) begin
    PINS <= LEVELS;
  end
endmodule

/* verif/test_supply_status_control_pins.sv */
// Self-checking bench for the rear connector status pin block
`timescale 1ns/10ps
`include "ssc_cfg.svh"
module test_supply_status_control_pins;
  localparam int DEB = 2;
  typedef struct packed {
    logic [15:0] v, i, p, l;
    logic [7:0] pn;
    logic [9:0] ev;
  } ssc_row_t;
  // Measurements and pins per case, and the sticky events they must leave
  localparam ssc_row_t ROWS [9] = '{
    {16'h1000, 16'h0100, 16'h0100, 16'h8000, 8'h5A, 10'h000},
    {16'h1001, 16'h0100, 16'h0100, 16'h8000, 8'h5A, 10'h001},
    {16'h0200, 16'h1001, 16'h0100, 16'h8000, 8'h5A, 10'h002},
    {16'h0200, 16'h0100, 16'hF001, 16'h8000, 8'h5A, 10'h004},
    {16'h0200, 16'h0100, 16'h0100, 16'h8000, 8'h7A, 10'h008},
    {16'h0200, 16'h0100, 16'h0100, 16'h8000, 8'h1A, 10'h010},
    {16'h0200, 16'h0100, 16'h0100, 16'h3FFF, 8'h5A, 10'h020},
    {16'h0200, 16'h0100, 16'h0100, 16'hC001, 8'h5A, 10'h020},
    {16'h0200, 16'h0100, 16'h0100, 16'h8000, 8'hDA, 10'h040}};
  localparam logic [7:0] RA [9] = '{`SSC_A_CTRL, `SSC_A_OVP, `SSC_A_OCP, `SSC_A_RISE,
    `SSC_A_FALL, `SSC_A_LINE_LO, `SSC_A_LINE_HI, `SSC_A_INT_MASK, 8'h28};
  localparam logic [31:0] RV [9] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h0100, 32'h0080,
    32'h0, 32'hFFFF, 32'h0, 32'h0};
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, pins, levels;
  logic [31:0] pwdata, prdata, rdat;
  ssc_pkg::ssc_word_t vout, iout, pout, line;
  logic out_en, act, mode, fault_n, otp_n, trig, irq;
  int mismatches = 0;
  int checks_done = 0;
  int n;

  ssc_status_pins #(.DEB_CYC(DEB)) uut (.MCLK(mclk), .RST_N(rst_n), .PADDR(paddr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SEQUENCE_TRIGGER_IN(pins[0]),
    .INHIBIT_IN_N(pins[1]), .TEMPORARY_OFF_IN(pins[2]), .REMOTE_ONOFF_IN_N(pins[3]),
    .CV_MODE_IN(pins[4]), .OTP_IN(pins[5]), .FAN_OK_IN(pins[6]),
    .SENSE_FAULT_IN(pins[7]), .VOUT_MEAS(vout), .IOUT_MEAS(iout), .POUT_MEAS(pout),
    .LINE_MEAS(line), .OUTPUT_ENABLE(out_en), .OUTPUT_ACTIVE_STATUS(act),
    .REGULATION_MODE_FLAG(mode), .FAULT_N(fault_n), .OTP_N(otp_n), .TRIG_PULSE(trig),
    .IRQ(irq));
  ssc_ext_equip ext (.MCLK(mclk), .LEVELS(levels), .PINS(pins));

  // Clock at 10 MHz
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, takes read data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic meas(input logic [15:0] v, i, p, l);
    @(posedge mclk);
    vout <= v;
    iout <= i;
    pout <= p;
    line <= l;
  endtask
  // Pin filter plus output register, with margin
  task automatic settle();
    repeat (DEB + 7) @(posedge mclk);
  endtask
  // Pin levels change only just after an edge and hold until the next call
  task automatic set_pins(input logic [7:0] v);
    @(posedge mclk);
    levels <= v;
  endtask
  // A trigger is a clean low-to-high step that stays high past the filter time
  task automatic trig_rise(input int hold);
    set_pins(levels | 8'h01);
    repeat (hold) @(posedge mclk);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vout = 16'h0200;
    iout = 16'h0100;
    pout = 16'h0100;
    line = 16'h8000;
    levels = 8'h5A;
    repeat (10) @(posedge mclk);
    chk({out_en, act, mode, fault_n, otp_n, trig, irq}, 7'b0011100);
    rst_n <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      rdchk(RA[k], RV[k]);
    end
    chk(rerr, 1'b1);
    chk(pready, 1'b1);
    apb(1'b1, `SSC_A_OVP, 32'h1000);
    apb(1'b1, `SSC_A_OCP, 32'h1000);
    apb(1'b1, `SSC_A_LINE_LO, 32'h4000);
    apb(1'b1, `SSC_A_LINE_HI, 32'hC000);
    set_pins(8'h4A);
    settle();
    chk(mode, 1'b0);
    set_pins(8'h5A);
    settle();
    chk(mode, 1'b1);
    // Protection causes from the table, one row at a time, cleared before the next
    for (int k = 0; k < 9; k++) begin
      meas(ROWS[k].v, ROWS[k].i, ROWS[k].p, ROWS[k].l);
      set_pins(ROWS[k].pn);
      settle();
      rdchk(`SSC_A_INT_STAT, {22'h0, ROWS[k].ev});
      chk(fault_n, ROWS[k].ev == 10'h0);
      chk(otp_n, !ROWS[k].ev[3]);
      meas(16'h0200, 16'h0100, 16'h0100, 16'h8000);
      set_pins(8'h5A);
      settle();
      apb(1'b1, `SSC_A_INT_STAT, 32'h3FF);
      settle();
    end
    // Output control, status thresholds with hysteresis
    apb(1'b1, `SSC_A_CTRL, 32'h1);
    settle();
    chk({out_en, act}, 2'b11);
    rdchk(`SSC_A_STATUS, 32'h0000001D);
    meas(16'h00C0, 16'h0100, 16'h0100, 16'h8000);
    settle();
    chk(act, 1'b1);
    meas(16'h007F, 16'h0100, 16'h0100, 16'h8000);
    settle();
    chk(act, 1'b0);
    meas(16'h0200, 16'h0100, 16'h0100, 16'h8000);
    set_pins(8'h5E);
    settle();
    chk(out_en, 1'b0);
    set_pins(8'h5A);
    settle();
    chk({out_en, act}, 2'b11);
    apb(1'b1, `SSC_A_CTRL, 32'h3);
    settle();
    chk(out_en, 1'b0);
    set_pins(8'h52);
    settle();
    chk(out_en, 1'b1);
    set_pins(8'h5A);
    settle();
    chk(out_en, 1'b0);
    apb(1'b1, `SSC_A_CTRL, 32'h1);
    set_pins(8'h58);
    settle();
    chk(out_en, 1'b0);
    set_pins(8'h5A);
    apb(1'b1, `SSC_A_CTRL, 32'h0);
    apb(1'b1, `SSC_A_CTRL, 32'h9);
    settle();
    chk(out_en, 1'b1);
    // Foldback both ways: each direction of mode change trips with its own enable bit set
    set_pins(8'h4A);
    settle();
    rdchk(`SSC_A_INT_STAT, 32'h080);
    apb(1'b1, `SSC_A_INT_STAT, 32'h3FF);
    apb(1'b1, `SSC_A_CTRL, 32'h0);
    apb(1'b1, `SSC_A_CTRL, 32'h11);
    settle();
    chk(out_en, 1'b1);
    set_pins(8'h5A);
    settle();
    rdchk(`SSC_A_INT_STAT, 32'h100);
    chk(out_en, 1'b0);
    apb(1'b1, `SSC_A_INT_STAT, 32'h3FF);
    apb(1'b1, `SSC_A_CTRL, 32'h0);
    apb(1'b1, `SSC_A_CTRL, 32'h1);
    settle();
    meas(16'h1001, 16'h0100, 16'h0100, 16'h8000);
    settle();
    chk({out_en, fault_n}, 2'b00);
    meas(16'h0200, 16'h0100, 16'h0100, 16'h8000);
    apb(1'b1, `SSC_A_INT_STAT, 32'h3FF);
    // Trigger pulse and the interrupt it raises
    apb(1'b1, `SSC_A_CTRL, 32'h4);
    apb(1'b1, `SSC_A_INT_MASK, 32'h200);
    trig_rise(0);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (trig !== 1'b1 && n < 20);
    chk(trig, 1'b1);
    @(posedge mclk);
    chk(trig, 1'b0);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    set_pins(8'h5A);
    apb(1'b1, `SSC_A_INT_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b1, `SSC_A_INT_MASK, 32'h200);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    apb(1'b1, `SSC_A_INT_STAT, 32'h200);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    // Trigger ignored while disabled, then a reset in mid-run
    apb(1'b1, `SSC_A_CTRL, 32'h0);
    trig_rise(DEB + 6);
    set_pins(8'h5A);
    settle();
    rdchk(`SSC_A_INT_STAT, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({out_en, act, mode, fault_n, otp_n, trig, irq}, 7'b0011100);
    rst_n <= 1'b1;
    rdchk(`SSC_A_INT_MASK, 32'h0);
    end_of_test();
  end
endmodule
